// >>> usbdma_pkg.sv
// Purpose: Shared constants and types for the endpoint DMA engine.
// Assumes: One 125 MHz clock; link packet logic and SRAM port run on it.
// Notes: Endpoint entries are eight bytes; entry index is {ep, bank} with ping-pong, else {ep, dirIn}.
package usbdma_pkg;
  localparam int EP_COUNT = 16;
  localparam logic [9:0] MAX_PAYLOAD = 10'h3FF;
  localparam logic [9:0] LS_MAX_PAYLOAD = 10'h008;
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_BUF_LO = 3'h1;
  localparam logic [2:0] OFS_BUF_HI = 3'h2;
  localparam logic [2:0] OFS_SIZE_LO = 3'h3;
  localparam logic [2:0] OFS_SIZE_HI = 3'h4;
  localparam logic [2:0] OFS_CNT_LO = 3'h5;
  localparam logic [2:0] OFS_CNT_HI = 3'h6;
  localparam logic [2:0] WB_LAST = 3'h4;
  localparam int CTRL_TYPE_LSB = 0;
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] TYPE_INTERRUPT = 2'h1;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [1:0] TYPE_ISOCHRONOUS = 2'h3;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CFG = 3'b001,
    ST_DATA = 3'b010,
    ST_WBACK = 3'b011,
    ST_DONE = 3'b100
  } usbdma_state_type;
endpackage

// >>> usbdma_endpoint_dma.sv
// Purpose: Endpoint DMA engine between link packet logic and system SRAM.
// Assumes: Link and SRAM port are on ref_clk; SRAM answers with memAck.
// Notes: Transaction results queue in a FIFO drained by software.
`timescale 1ns/10ps
module usbdma_endpoint_dma import usbdma_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic usbEnable,
  input wire logic fullSpeed,
  input wire logic [15:0] epTablePtr,
  input wire logic [EP_COUNT-1:0] ppEnable,
  input wire logic [EP_COUNT-1:0] mpEnable,
  input wire logic [1:0] clkSelect,
  output logic [1:0] clkSourceSel,
  input wire logic tokValid,
  input wire logic [3:0] tokEp,
  input wire logic tokDirIn,
  input wire logic tokSetup,
  output logic tokReady,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxLast,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic txReady,
  output logic memReq,
  output logic memWe,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic memAck,
  input wire logic [7:0] memRdata,
  output logic doneValid,
  output logic [3:0] doneEp,
  output logic doneDirIn,
  output logic [1:0] doneType,
  input wire logic donePop,
  output logic eventPulse,
  output logic [EP_COUNT-1:0] ppBank,
  output logic busy
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    usbdma_state_type st;
    logic [3:0] ep;
    logic dirIn;
    logic setup;
    logic [7:0] ctrl;
    logic [15:0] bufAddr;
    logic [9:0] maxSize;
    logic [9:0] cnt;
    logic [9:0] idx;
    logic [2:0] step;
    logic rxEnd;
    logic memReq;
    logic memWe;
    logic [15:0] memAddr;
    logic [7:0] memWdata;
    logic [EP_COUNT-1:0] bank;
    logic [1:0][8:0] txq;
    logic [1:0] txN;
    logic txHead;
    logic [DEPTH-1:0][6:0] fifo;
    logic [PW:0] wp;
    logic [PW:0] rp;
    logic evt;
    logic [1:0] clkSel;
  } usbdma_regs_type;

  usbdma_regs_type s;
  usbdma_regs_type next_s;
  logic [15:0] entryBase;
  logic [9:0] limit;
  logic [9:0] cap;
  logic shortPkt;
  logic report;
  logic fifoFull;
  logic doneLeave;
  logic txPop;
  logic [2:0] wbOfs;
  logic [15:0] newBuf;
  logic [7:0] wbByte;

  assign tokReady = (s.st == ST_IDLE) && usbEnable;
  assign rxReady = (s.st == ST_DATA) && !s.dirIn && !s.memReq && !s.rxEnd;
  assign txValid = s.txN != 2'h0;
  assign txData = s.txq[s.txHead][7:0];
  assign txLast = s.txq[s.txHead][8];
  assign txPop = txValid && txReady;
  assign memReq = s.memReq;
  assign memWe = s.memWe;
  assign memAddr = s.memAddr;
  assign memWdata = s.memWdata;
  assign fifoFull = (s.wp[PW-1:0] == s.rp[PW-1:0]) && (s.wp[PW] != s.rp[PW]);
  assign doneValid = s.wp != s.rp;
  assign {doneType, doneDirIn, doneEp} = s.fifo[s.rp[PW-1:0]];
  assign eventPulse = s.evt;
  assign ppBank = s.bank;
  assign clkSourceSel = s.clkSel;
  assign busy = s.st != ST_IDLE;
  // Ping-pong points both directions at the bank entry.
  assign entryBase = epTablePtr + {7'h00, s.ep, (ppEnable[s.ep] ? s.bank[s.ep] : s.dirIn),
    4'h0} / 16'h0002;
  assign cap = fullSpeed ? MAX_PAYLOAD : LS_MAX_PAYLOAD;
  assign limit = (s.cnt < s.maxSize) ? s.cnt : s.maxSize;
  assign shortPkt = s.idx < s.maxSize;
  assign report = !mpEnable[s.ep] || shortPkt;
  assign doneLeave = (s.st == ST_DONE) && !(report && fifoFull);
  assign newBuf = mpEnable[s.ep] ? (s.bufAddr + {6'h00, s.idx}) : s.bufAddr;
  assign wbOfs = (s.step < 3'h2) ? (OFS_BUF_LO + s.step) : (OFS_CNT_LO + s.step - 3'h2);

  always_comb begin
    next_s = s;
    next_s.evt = 1'b0;
    next_s.clkSel = clkSelect;
    wbByte = 8'h00;
    if (s.memReq && memAck) begin
      next_s.memReq = 1'b0;
    end
    if (txPop) begin
      next_s.txHead = ~s.txHead;
      next_s.txN = s.txN - 2'h1;
    end
    if (donePop && doneValid) begin
      next_s.rp = s.rp + 1'b1;
    end
    case (s.st)
      ST_IDLE: begin
        if (tokValid && usbEnable) begin
          next_s.ep = tokEp;
          next_s.dirIn = tokDirIn;
          next_s.setup = tokSetup;
          next_s.step = OFS_CTRL;
          next_s.idx = 10'h000;
          next_s.rxEnd = 1'b0;
          next_s.st = ST_CFG;
        end
      end
      ST_CFG: begin
        // Configuration is fetched fresh per transaction.
        if (!s.memReq) begin
          next_s.memWe = 1'b0;
          next_s.memAddr = entryBase + {13'h0000, s.step};
          next_s.memReq = 1'b1;
        end else if (memAck) begin
          case (s.step)
            OFS_CTRL: next_s.ctrl = memRdata;
            OFS_BUF_LO: next_s.bufAddr[7:0] = memRdata;
            OFS_BUF_HI: next_s.bufAddr[15:8] = memRdata;
            OFS_SIZE_LO: next_s.maxSize[7:0] = memRdata;
            OFS_SIZE_HI: begin
              next_s.maxSize = ({memRdata[1:0], s.maxSize[7:0]} > cap) ? cap :
                {memRdata[1:0], s.maxSize[7:0]};
            end
            OFS_CNT_LO: next_s.cnt[7:0] = memRdata;
            default: next_s.cnt[9:8] = memRdata[1:0];
          endcase
          next_s.step = s.step + 3'h1;
          if (s.step == OFS_CNT_HI) begin
            next_s.step = 3'h0;
            // Setup tokens are only honoured on control endpoints.
            next_s.st = (s.setup && s.ctrl[CTRL_TYPE_LSB+:2] != TYPE_CONTROL) ? ST_IDLE :
              ST_DATA;
          end
        end
      end
      ST_DATA: begin
        // Buffers are read byte by byte, so CPU updates land in flight.
        if (s.dirIn) begin
          if (s.memReq && memAck) begin
            next_s.txq[s.txHead ^ s.txN[0]] = {s.idx == limit, memRdata};
            next_s.txN = next_s.txN + 2'h1;
          end
          if (!s.memReq && (s.idx < limit) && (s.txN < 2'h2)) begin
            next_s.memWe = 1'b0;
            next_s.memAddr = s.bufAddr + {6'h00, s.idx};
            next_s.memReq = 1'b1;
            next_s.idx = s.idx + 10'h001;
          end
          if (!s.memReq && (s.idx == limit) && (s.txN == 2'h0)) begin
            next_s.st = ST_WBACK;
          end
        end else begin
          if (rxValid && rxReady) begin
            if (s.idx < s.maxSize) begin
              next_s.memWe = 1'b1;
              next_s.memAddr = s.bufAddr + {6'h00, s.idx};
              next_s.memWdata = rxData;
              next_s.memReq = 1'b1;
              next_s.idx = s.idx + 10'h001;
            end
            next_s.rxEnd = rxLast;
          end
          if (s.rxEnd && !s.memReq) begin
            next_s.st = ST_WBACK;
          end
        end
      end
      ST_WBACK: begin
        // Pointer and count go back; the pointer advances so the next packet continues only on multipacket endpoints.
        if (!s.memReq) begin
          if (s.step == WB_LAST) begin
            next_s.st = ST_DONE;
          end else begin
            case (s.step)
              3'h0: wbByte = newBuf[7:0];
              3'h1: wbByte = newBuf[15:8];
              3'h2: wbByte = s.dirIn ? (s.cnt[7:0] - s.idx[7:0]) : s.idx[7:0];
              default: wbByte = {6'h00, s.dirIn ? (s.cnt[9:8] - s.idx[9:8] -
                {1'b0, s.cnt[7:0] < s.idx[7:0]}) : s.idx[9:8]};
            endcase
            next_s.memWe = 1'b1;
            next_s.memAddr = entryBase + {13'h0000, wbOfs};
            next_s.memWdata = wbByte;
            next_s.memReq = 1'b1;
            next_s.step = s.step + 3'h1;
          end
        end
      end
      ST_DONE: begin
        if (doneLeave) begin
          if (ppEnable[s.ep]) begin
            next_s.bank[s.ep] = ~s.bank[s.ep];
          end
          if (report) begin
            next_s.fifo[s.wp[PW-1:0]] = {s.ctrl[CTRL_TYPE_LSB+:2], s.dirIn, s.ep};
            next_s.wp = s.wp + 1'b1;
            next_s.evt = 1'b1;
          end
          next_s.st = ST_IDLE;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  sequence sTokTaken;
    tokValid && tokReady;
  endsequence
  sequence sReported;
    doneLeave && report;
  endsequence

  a_tok_fetch_cfg: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sTokTaken |=> (s.st == ST_CFG) ##1 (memReq && !memWe && memAddr == $past(entryBase)))
    else $error("token did not start a configuration fetch");
  a_cfg_read_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s.st == ST_CFG) && memReq |-> !memWe)
    else $error("configuration fetch wrote SRAM");
  a_payload_cap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s.st == ST_DATA) |-> (s.idx <= MAX_PAYLOAD) && (s.maxSize <= cap))
    else $error("payload beyond size limit");
  a_setup_type: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s.st == ST_CFG) && memAck && s.memReq && (s.step == OFS_CNT_HI) && s.setup &&
    (s.ctrl[1:0] != TYPE_CONTROL) |=> (s.st == ST_IDLE))
    else $error("setup accepted on a non-control endpoint");
  a_pp_toggle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    doneLeave && ppEnable[s.ep] |=> ppBank[$past(s.ep)] != $past(ppBank[s.ep]))
    else $error("ping-pong bank did not flip");
  a_fifo_push: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sReported ##0 !doneValid |=> doneValid && doneEp == $past(s.ep))
    else $error("completion not queued");
  a_event_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
    eventPulse |-> $past(doneLeave && report) ##1 !eventPulse)
    else $error("event without a queued completion");
  a_mp_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    doneLeave && mpEnable[s.ep] && !shortPkt |=> !eventPulse)
    else $error("multipacket raised an event per packet");
  a_clk_select: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ##1 clkSourceSel == $past(clkSelect))
    else $error("clock source selection not followed");
endmodule

// >>> usbdma_sram_model.sv
// Purpose: Byte-wide SRAM on the engine's memory port.
// Assumes: One request at a time, answered after waitCycles + 1 edges.
// Notes: Read data toggles outside an answer.
`timescale 1ns/10ps
module usbdma_sram_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [1:0] waitCycles,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic memAck,
  output logic [7:0] memRdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] waitCount;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      memAck <= 1'b0;
      waitCount <= 2'h0;
      memRdata <= 8'h00;
    end else if (memReq && !memAck && waitCount == waitCycles) begin
      memAck <= 1'b1;
      waitCount <= 2'h0;
      if (memWe) begin
        mem[memAddr] <= memWdata;
      end else begin
        memRdata <= mem[memAddr];
      end
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck) begin
        waitCount <= waitCount + 2'h1;
      end
    end
  end
endmodule

// >>> usbdma_endpoint_dma_tb.sv
// Purpose: Self-checking bench for the endpoint DMA engine.
// Assumes: Endpoint table at 16'h0100 in the SRAM model.
// Notes: Inputs change on the falling edge of ref_clk.
`timescale 1ns/10ps
module usbdma_endpoint_dma_tb import usbdma_pkg::*;;
  localparam logic [15:0] TBL = 16'h0100;
  logic ref_clk = 0, rst_b = 0, usbEnable = 1, fullSpeed = 1, tokValid = 0, tokDirIn = 0;
  logic tokSetup = 0, rxValid = 0, rxLast = 0, txReady = 0, donePop = 0;
  logic tokReady, rxReady, txValid, txLast, memReq, memWe, memAck;
  logic doneValid, doneDirIn, eventPulse, busy;
  logic [1:0] clkSelect = 2'h0, waitCycles = 2'h0, clkSourceSel, doneType;
  logic [3:0] tokEp = 4'h0, doneEp;
  logic [7:0] rxData = 8'h00, txData, memWdata, memRdata;
  logic [15:0] epTablePtr = TBL, memAddr;
  logic [EP_COUNT-1:0] ppEnable = 16'h0000, mpEnable = 16'h0000, ppBank;
  int errCount = 0, totalChecks = 0, cycles = 0, evCount = 0;
  usbdma_endpoint_dma DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .usbEnable(usbEnable), .fullSpeed(fullSpeed),
    .epTablePtr(epTablePtr), .ppEnable(ppEnable), .mpEnable(mpEnable),
    .clkSelect(clkSelect), .clkSourceSel(clkSourceSel),
    .tokValid(tokValid), .tokEp(tokEp), .tokDirIn(tokDirIn), .tokSetup(tokSetup),
    .tokReady(tokReady),
    .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxReady(rxReady),
    .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memAck(memAck), .memRdata(memRdata),
    .doneValid(doneValid), .doneEp(doneEp), .doneDirIn(doneDirIn), .doneType(doneType),
    .donePop(donePop), .eventPulse(eventPulse), .ppBank(ppBank), .busy(busy)
  );
  usbdma_sram_model sram (
    .ref_clk(ref_clk), .rst_b(rst_b), .waitCycles(waitCycles),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memAck(memAck), .memRdata(memRdata)
  );
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    cycles++;
    if (eventPulse === 1'b1) evCount++;
    if (cycles == 20000) begin
      errCount++;
      stopTest;
    end
  end
  task automatic stopTest;
    $display("Checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] ent(input int idx);
    return TBL + 16'(8 * idx);
  endfunction
  function automatic logic [15:0] rd16(input logic [15:0] a);
    return {sram.mem[a + 16'h1], sram.mem[a]};
  endfunction
  task automatic set_ep(input int idx, input logic [1:0] typ, input logic [15:0] bufAddr,
                        input logic [9:0] size, input logic [9:0] cnt);
    logic [15:0] a;
    a = ent(idx);
    sram.mem[a] = {6'h00, typ};
    sram.mem[a + 16'h1] = bufAddr[7:0];
    sram.mem[a + 16'h2] = bufAddr[15:8];
    sram.mem[a + 16'h3] = size[7:0];
    sram.mem[a + 16'h4] = {6'h00, size[9:8]};
    sram.mem[a + 16'h5] = cnt[7:0];
    sram.mem[a + 16'h6] = {6'h00, cnt[9:8]};
  endtask
  task automatic wait_idle;
    repeat (2) @(negedge ref_clk);
    while (busy !== 1'b0) @(negedge ref_clk);
  endtask
  task automatic token(input logic [3:0] ep, input logic dirIn, input logic setup);
    @(negedge ref_clk);
    tokValid = 1;
    tokEp = ep;
    tokDirIn = dirIn;
    tokSetup = setup;
    while (tokReady !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    tokValid = 0;
  endtask
  task automatic send_out(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      rxValid = 1;
      rxData = base + 8'(i);
      rxLast = (i == n - 1);
      while (rxReady !== 1'b1) @(negedge ref_clk);
    end
    @(negedge ref_clk);
    rxValid = 0;
    rxLast = 0;
    wait_idle;
  endtask
  task automatic recv_in(input int n, input logic [7:0] base);
    int k;
    k = 0;
    while (k < n) begin
      @(negedge ref_clk);
      txReady = !txReady;
      if (txValid === 1'b1 && txReady) begin
        chk(txData, base + 8'(k));
        chk(txLast, k == n - 1);
        k++;
      end
    end
    @(negedge ref_clk);
    txReady = 0;
    wait_idle;
  endtask
  task automatic pop_check(input logic [3:0] ep, input logic dirIn, input logic [1:0] typ);
    chk(doneValid, 1);
    chk({doneType, doneDirIn, doneEp}, {typ, dirIn, ep});
    @(negedge ref_clk);
    donePop = 1;
    @(negedge ref_clk);
    donePop = 0;
  endtask
  initial begin
    for (int i = 0; i < 16; i++) begin
      sram.mem[16'h0900 + i] = 8'h50 + 8'(i);
    end
    repeat (20) @(negedge ref_clk);
    rst_b = 1;
    clkSelect = 2'h2;
    @(negedge ref_clk);
    chk(clkSourceSel, 2'h2);
    $display("Test clock select finished");
    set_ep(4, TYPE_BULK, 16'h0800, 8, 0);
    token(2, 0, 0);
    send_out(3, 8'hA0);
    for (int i = 0; i < 3; i++) chk(sram.mem[16'h0800 + i], 8'hA0 + 8'(i));
    chk(rd16(ent(4) + 16'h5), 3);
    pop_check(2, 0, TYPE_BULK);
    set_ep(7, TYPE_INTERRUPT, 16'h0900, 2, 4);
    token(3, 1, 0);
    recv_in(2, 8'h50);
    chk(rd16(ent(7) + 16'h5), 2);
    $display("Test OUT and IN finished");
    ppEnable = 16'h0020;
    waitCycles = 2'h2;
    set_ep(10, TYPE_BULK, 16'h0A00, 8, 0);
    set_ep(11, TYPE_BULK, 16'h0B00, 8, 0);
    for (int j = 0; j < 2; j++) begin
      chk(ppBank[5], j[0]);
      token(5, 0, 0);
      send_out(2, 8'h10 + 8'(16 * j));
      chk(sram.mem[16'h0A00 + 16'(256 * j)], 8'h10 + 8'(16 * j));
    end
    chk(ppBank[5], 0);
    pop_check(3, 1, TYPE_INTERRUPT);
    pop_check(5, 0, TYPE_BULK);
    pop_check(5, 0, TYPE_BULK);
    $display("Test ping-pong finished");
    set_ep(8, TYPE_BULK, 16'h0E00, 8, 0);
    token(4, 0, 1);
    wait_idle;
    chk(doneValid, 0);
    set_ep(0, TYPE_CONTROL, 16'h0E00, 8, 0);
    token(0, 0, 1);
    send_out(1, 8'h77);
    pop_check(0, 0, TYPE_CONTROL);
    mpEnable = 16'h0040;
    set_ep(12, TYPE_BULK, 16'h0C00, 2, 0);
    token(6, 0, 0);
    send_out(2, 8'h30);
    chk(doneValid, 0);
    chk(rd16(ent(12) + 16'h1), 16'h0C02);
    token(6, 0, 0);
    send_out(1, 8'h32);
    chk(sram.mem[16'h0C02], 8'h32);
    pop_check(6, 0, TYPE_BULK);
    $display("Test setup and multipacket finished");
    fullSpeed = 0;
    waitCycles = 2'h1;
    set_ep(31, TYPE_ISOCHRONOUS, 16'h0D00, 16, 12);
    token(15, 1, 0);
    for (int i = 0; i < 8; i++) sram.mem[16'h0D00 + i] = 8'h60 + 8'(i);
    recv_in(8, 8'h60);
    chk(rd16(ent(31) + 16'h5), 4);
    pop_check(15, 1, TYPE_ISOCHRONOUS);
    chk(evCount, 7);
    $display("Test low speed finished");
    stopTest;
  end
endmodule
